//--- verilog/sqw_encoder.sv
/*
 * Encoder end: turns step requests into two quadrature square waves,
 * a gated reference pulse, complementary copies and a fault output.
 * Assumes step requests and fault sense come from logic on sys_clk.
 */
`timescale 1ns/1ns
`default_nettype none
`include "sqw_defines.svh"

// How it works
// - two trains a quarter period apart
// - reference pulses gated with both trains
// - complementary copy of each track and the reference driven
// - second lagging first means forward motion
// - fault output low on malfunction, else high
// - fault low pulse lasts at least 20 ms
// - reference pulse spans 90 electrical degrees
// - counter picks 1x, 2x or 4x evaluation
// - counter sees every edge of both trains
// - reference taken only with both trains high
// - counter treats reference, fault, complements optional
module sqw_encoder #(
	parameter int unsigned FAULT_CYCLES = `SQW_FAULT_CYCLES
) (
	// Clock and reset
	input  wire logic      sys_clk,
	input  wire logic      arst_n,
	// User side
	input  wire logic      step_req,
	input  wire logic      step_reverse,
	input  wire logic      ref_mark,
	input  wire logic      malfunction,
	output logic [1:0]     phase_q,
	// Link
	sqw_link_if.encoder    link
);
	localparam int unsigned FW = $clog2(FAULT_CYCLES + 1);

	// ------------------------------------------------------------------
	// Quadrature phase
	// ------------------------------------------------------------------
	// Forward walks 00,01,11,10 on {second,first}, so first leads
	function automatic sqw_pkg::sqw_quad_st_t next_quad(
		input sqw_pkg::sqw_quad_st_t s,
		input logic                  rev
	);
		unique case (s)
			sqw_pkg::SQW_Q_00: next_quad = rev ? sqw_pkg::SQW_Q_10 : sqw_pkg::SQW_Q_01;
			sqw_pkg::SQW_Q_01: next_quad = rev ? sqw_pkg::SQW_Q_00 : sqw_pkg::SQW_Q_11;
			sqw_pkg::SQW_Q_11: next_quad = rev ? sqw_pkg::SQW_Q_01 : sqw_pkg::SQW_Q_10;
			sqw_pkg::SQW_Q_10: next_quad = rev ? sqw_pkg::SQW_Q_11 : sqw_pkg::SQW_Q_00;
			// A corrupted code falls back to the rest state
			default:           next_quad = sqw_pkg::SQW_Q_00;
		endcase
	endfunction

	// Returns {second, first}; neighbouring states differ in one bit
	function automatic logic [1:0] tracks(input sqw_pkg::sqw_quad_st_t s);
		unique case (s)
			sqw_pkg::SQW_Q_00: tracks = 2'h0;
			sqw_pkg::SQW_Q_01: tracks = 2'h1;
			sqw_pkg::SQW_Q_11: tracks = 2'h3;
			sqw_pkg::SQW_Q_10: tracks = 2'h2;
			default:           tracks = 2'h0;
		endcase
	endfunction

	// One state per request, so a request can never skip an edge
	sqw_pkg::sqw_quad_st_t quad_q;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			quad_q <= sqw_pkg::SQW_Q_00;
		end else if (step_req) begin
			quad_q <= next_quad(quad_q, step_reverse);
		end
	end

	// ------------------------------------------------------------------
	// Fault hold
	// ------------------------------------------------------------------
	// A fault that outlasts the width keeps the line low until it clears
	sqw_pkg::sqw_fault_st_t st_q;
	logic [FW-1:0]          fcnt_q;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= sqw_pkg::SQW_F_OK;
		end else begin
			unique case (st_q)
				sqw_pkg::SQW_F_OK: begin
					if (malfunction) begin
						st_q <= sqw_pkg::SQW_F_HOLD;
					end
				end
				sqw_pkg::SQW_F_HOLD: begin
					// Stay low for the full width even if the fault clears early
					if (fcnt_q == '0 && !malfunction) begin
						st_q <= sqw_pkg::SQW_F_OK;
					end
				end
				default: st_q <= sqw_pkg::SQW_F_OK;
			endcase
		end
	end

	// The output flop adds one cycle, a margin over the least width
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			fcnt_q <= '0;
		end else if (st_q == sqw_pkg::SQW_F_OK) begin
			fcnt_q <= malfunction ? FW'(FAULT_CYCLES - 1) : '0;
		end else if (fcnt_q != '0) begin
			fcnt_q <= fcnt_q - FW'(1);
		end
	end

	// ------------------------------------------------------------------
	// Track and reference drive
	// ------------------------------------------------------------------
	logic [1:0] tr_d;
	logic       ref_d;
	always_comb begin
		tr_d  = tracks(quad_q);
		// Both high is one quarter of the period, hence 90 degrees wide
		ref_d = ref_mark && (tr_d == 2'h3);
	end

	// Tracks and reference switch on one edge, so the gating holds on the wire
	logic a_q, b_q, r_q;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			a_q <= 1'b0;
			b_q <= 1'b0;
		end else begin
			a_q <= tr_d[0];
			b_q <= tr_d[1];
		end
	end

	// Only the nominal width is built; wider reference variants are left out
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			r_q <= 1'b0;
		end else begin
			r_q <= ref_d;
		end
	end

	// ------------------------------------------------------------------
	// Fault drive and phase report
	// ------------------------------------------------------------------
	logic f_q;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			f_q <= 1'b1;
		end else begin
			// Fault sense pulls the line low at once, ahead of the hold state
			f_q <= (st_q == sqw_pkg::SQW_F_OK) && !malfunction;
		end
	end

	// Binary phase count from the track levels, aligned with the wires
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			phase_q <= 2'h0;
		end else begin
			phase_q <= tr_d ^ {1'b0, tr_d[1]};
		end
	end

	// ------------------------------------------------------------------
	// Complementary drive
	// ------------------------------------------------------------------
	// Complements come from their own flops so both wires switch together
	logic an_q, bn_q, rn_q;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			an_q <= 1'b1;
			bn_q <= 1'b1;
		end else begin
			an_q <= !tr_d[0];
			bn_q <= !tr_d[1];
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rn_q <= 1'b1;
		end else begin
			rn_q <= !ref_d;
		end
	end

	// ------------------------------------------------------------------
	// Link wiring
	// ------------------------------------------------------------------
	// All seven wires come straight from flops, never from gates
	assign link.incr_track_first    = a_q;
	assign link.incr_track_first_n  = an_q;
	assign link.incr_track_second   = b_q;
	assign link.incr_track_second_n = bn_q;
	assign link.ref_pulse           = r_q;
	assign link.ref_pulse_n         = rn_q;
	assign link.fault_indication_n  = f_q;
endmodule

`default_nettype wire

//--- verilog/sqw_defines.svh
/*
 * Timing counts and evaluation mode codes for the square-wave quadrature link.
 * Assumes a 100 MHz system clock shared by both ends.
 */
`ifndef SQW_DEFINES_SVH
`define SQW_DEFINES_SVH

// ----------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------
`define SQW_CLK_MHZ          100
`define SQW_FAULT_WIDTH_MS   20
// Least time, so rounded up; 20 ms at 100 MHz is 2,000,000 cycles
`define SQW_FAULT_CYCLES     ((`SQW_FAULT_WIDTH_MS * 1000 * `SQW_CLK_MHZ + 0) / 1)

// ----------------------------------------------------------------------
// Evaluation mode codes
// ----------------------------------------------------------------------
`define SQW_EVAL_X1          2'h1
`define SQW_EVAL_X2          2'h2
`define SQW_EVAL_X4          2'h3

`endif

//--- verilog/sqw_pkg.sv
/*
 * Types shared by both ends of the square-wave quadrature link.
 * Assumes sqw_defines.svh for the numeric constants.
 */
`default_nettype none

package sqw_pkg;

	// Quadrature track state, named by {second, first}
	typedef enum logic [3:0] {
		SQW_Q_00 = 4'b0001,
		SQW_Q_01 = 4'b0010,
		SQW_Q_11 = 4'b0100,
		SQW_Q_10 = 4'b1000
	} sqw_quad_st_t;

	// Counter evaluation factor
	typedef enum logic [1:0] {
		SQW_EVAL_NONE_T = 2'h0,
		SQW_EVAL_1X     = 2'h1,
		SQW_EVAL_2X     = 2'h2,
		SQW_EVAL_4X     = 2'h3
	} sqw_eval_t;

	// Encoder fault output state
	typedef enum logic [1:0] {
		SQW_F_OK   = 2'b01,
		SQW_F_HOLD = 2'b10
	} sqw_fault_st_t;

endpackage

`default_nettype wire

//--- verilog/sqw_link_if.sv
/*
 * Wires of the square-wave quadrature link, with modports for the
 * encoder and the counting electronics.
 * Assumes both ends share sys_clk; the bench joins the two ends here.
 */
`timescale 1ns/1ns
`default_nettype none

interface sqw_link_if;
	logic incr_track_first;
	logic incr_track_first_n;
	logic incr_track_second;
	logic incr_track_second_n;
	logic ref_pulse;
	logic ref_pulse_n;
	logic fault_indication_n;

	modport encoder (
		output incr_track_first,
		output incr_track_first_n,
		output incr_track_second,
		output incr_track_second_n,
		output ref_pulse,
		output ref_pulse_n,
		output fault_indication_n
	);

	modport counter (
		input incr_track_first,
		input incr_track_first_n,
		input incr_track_second,
		input incr_track_second_n,
		input ref_pulse,
		input ref_pulse_n,
		input fault_indication_n
	);
endinterface

`default_nettype wire

//--- verilog/sqw_counter.sv
/*
 * Counter end: synchronises the link, counts steps at 1x/2x/4x,
 * qualifies reference events and flags illegal transitions.
 * Assumes the link is asynchronous to sys_clk; edges at least 3 cycles apart.
 */
`timescale 1ns/1ns
`default_nettype none
`include "sqw_defines.svh"

module sqw_counter #(
	parameter int unsigned CW = 32
) (
	// Clock and reset
	input  wire logic               sys_clk,
	input  wire logic               arst_n,
	// Configuration
	input  wire sqw_pkg::sqw_eval_t eval_mode,
	input  wire logic               use_diff,
	input  wire logic               ref_present,
	input  wire logic               fault_present,
	// Results
	output logic [CW-1:0]           position_q,
	output logic                    step_q,
	output logic                    ref_event_q,
	output logic                    trans_err_q,
	output logic                    fault_q,
	// Link
	sqw_link_if.counter             link
);
	// ------------------------------------------------------------------
	// Two-stage synchronisers
	// ------------------------------------------------------------------
	logic [6:0] s1_q, s2_q;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			s1_q <= 7'h40;
			s2_q <= 7'h40;
		end else begin
			s1_q <= {link.fault_indication_n, link.ref_pulse_n, link.ref_pulse,
			         link.incr_track_second_n, link.incr_track_second,
			         link.incr_track_first_n, link.incr_track_first};
			s2_q <= s1_q;
		end
	end

	// Missing complements or reference are tolerated by mode inputs
	logic a, b, r, fn;
	always_comb begin
		a  = use_diff ? (s2_q[0] & ~s2_q[1]) : s2_q[0];
		b  = use_diff ? (s2_q[2] & ~s2_q[3]) : s2_q[2];
		r  = ref_present && (use_diff ? (s2_q[4] & ~s2_q[5]) : s2_q[4]);
		fn = fault_present ? s2_q[6] : 1'b1;
	end

	// ------------------------------------------------------------------
	// Edge decode
	// ------------------------------------------------------------------
	logic a_q, b_q;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			a_q <= 1'b0;
			b_q <= 1'b0;
		end else begin
			a_q <= a;
			b_q <= b;
		end
	end

	logic ea, eb, fwd, cnt;
	always_comb begin
		ea  = a ^ a_q;
		eb  = b ^ b_q;
		// Forward when the second track lags: b follows a
		fwd = ea ? (a != b) : (a == b);
		unique case (eval_mode)
			sqw_pkg::SQW_EVAL_1X: cnt = ea && a && fwd || ea && !a && !fwd;
			sqw_pkg::SQW_EVAL_2X: cnt = ea;
			sqw_pkg::SQW_EVAL_4X: cnt = ea || eb;
			default:              cnt = ea || eb;
		endcase
		if (ea && eb) begin
			cnt = 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Position, reference, errors
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			position_q <= '0;
			step_q     <= 1'b0;
		end else begin
			step_q <= cnt;
			if (cnt) begin
				position_q <= fwd ? position_q + CW'(1) : position_q - CW'(1);
			end
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ref_event_q <= 1'b0;
			trans_err_q <= 1'b0;
			fault_q     <= 1'b0;
		end else begin
			ref_event_q <= r && a && b && (ea || eb);
			trans_err_q <= ea && eb;
			fault_q     <= !fn;
		end
	end
endmodule

`default_nettype wire

//--- sim/sqw_link_assertions.sv
/* Checker on the seven link wires between encoder and counter.
   Assumes the bench clock and reset; FAULT_CYCLES matches the encoder. */
`timescale 1ns/1ns
`default_nettype none
module sqw_link_assertions #(
	parameter int unsigned FAULT_CYCLES = 20
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Link
	input wire logic incr_track_first,
	input wire logic incr_track_first_n,
	input wire logic incr_track_second,
	input wire logic incr_track_second_n,
	input wire logic ref_pulse,
	input wire logic ref_pulse_n,
	input wire logic fault_indication_n
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	// Length of the current fault low, to check the least width on release
	logic [31:0] low_cnt_q;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n)
			low_cnt_q <= 32'h0000_0000;
		else if (fault_indication_n)
			low_cnt_q <= 32'h0000_0000;
		else
			low_cnt_q <= low_cnt_q + 32'h0000_0001;
	end
	a_first_comp: assert property (incr_track_first_n == !incr_track_first)
		else $error("first track complement wrong");
	a_second_comp: assert property (incr_track_second_n == !incr_track_second)
		else $error("second track complement wrong");
	a_ref_comp: assert property (ref_pulse_n == !ref_pulse)
		else $error("reference complement wrong");
	a_one_edge: assert property (!($changed(incr_track_first) && $changed(incr_track_second)))
		else $error("both tracks changed together");
	a_ref_gated: assert property (ref_pulse |-> incr_track_first && incr_track_second)
		else $error("reference outside both tracks high");
	a_ref_drops: assert property ($fell(incr_track_first) || $fell(incr_track_second) |-> !ref_pulse)
		else $error("reference wider than one state");
	a_fault_stays: assert property ($fell(fault_indication_n) |=> !fault_indication_n [*8])
		else $error("fault low pulse too short");
	a_fault_width: assert property ($rose(fault_indication_n) |-> low_cnt_q >= FAULT_CYCLES)
		else $error("fault low shorter than least width");
endmodule
`default_nettype wire

//--- sim/square_wave_quadrature_link_test.sv
/* Self-checking bench: encoder and counter joined by the link interface.
   Assumes one 100 MHz clock; a short fault width keeps the run brief. */
`timescale 1ns/1ns
`default_nettype none
module square_wave_quadrature_link_test;
	localparam int unsigned FC = 20;
	logic               sys_clk = 1'h0;
	logic               arst_n = 1'h0;
	logic               step_req = 1'h0;
	logic               step_reverse = 1'h0;
	logic               ref_mark = 1'h0;
	logic               malfunction = 1'h0;
	sqw_pkg::sqw_eval_t eval_mode = sqw_pkg::SQW_EVAL_4X;
	logic               use_diff = 1'h1;
	logic               ref_present = 1'h1;
	logic               fault_present = 1'h1;
	logic [31:0]        position_q;
	logic               ref_event_q;
	logic               fault_q;
	logic [1:0]         phase_q;
	logic               step_q;
	logic               trans_err_q;
	int                 step_cnt = 0;
	int                 err_cnt = 0;
	int                 fails = 0;
	int                 comparisons = 0;
	int                 ref_cnt = 0;
	int                 seed = 32'hcd38_aa6f;
	sqw_link_if sqw_link_if_i ();
	sqw_encoder #(.FAULT_CYCLES(FC)) sqw_encoder_i (.sys_clk(sys_clk), .arst_n(arst_n),
		.step_req(step_req), .step_reverse(step_reverse), .ref_mark(ref_mark),
		.malfunction(malfunction), .phase_q(phase_q), .link(sqw_link_if_i.encoder));
	sqw_counter sqw_counter_i (.sys_clk(sys_clk), .arst_n(arst_n), .eval_mode(eval_mode),
		.use_diff(use_diff), .ref_present(ref_present), .fault_present(fault_present),
		.position_q(position_q), .step_q(step_q), .ref_event_q(ref_event_q),
		.trans_err_q(trans_err_q),
		.fault_q(fault_q), .link(sqw_link_if_i.counter));
	sqw_link_assertions #(.FAULT_CYCLES(FC)) sqw_link_assertions_i (.sys_clk(sys_clk),
		.arst_n(arst_n), .incr_track_first(sqw_link_if_i.incr_track_first),
		.incr_track_first_n(sqw_link_if_i.incr_track_first_n),
		.incr_track_second(sqw_link_if_i.incr_track_second),
		.incr_track_second_n(sqw_link_if_i.incr_track_second_n),
		.ref_pulse(sqw_link_if_i.ref_pulse), .ref_pulse_n(sqw_link_if_i.ref_pulse_n),
		.fault_indication_n(sqw_link_if_i.fault_indication_n));
	initial begin
		forever #5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		if (ref_event_q === 1'h1)
			ref_cnt++;
		if (step_q === 1'h1)
			step_cnt++;
		if (trans_err_q === 1'h1)
			err_cnt++;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic wrap_up();
		$display("fails %0d comparisons %0d", fails, comparisons);
		if (fails == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Watchdog well beyond the roughly 510 cycles the tests need
	initial begin
		#200000;
		fails++;
		wrap_up();
	end
	initial begin
		logic [1:0] seq [4];
		int         idx;
		int         nx;
		int         pos;
		int         refs;
		int         d;
		int         steps;
		int         p0;
		seq = '{2'h0, 2'h1, 2'h3, 2'h2};
		idx = 0;
		pos = 0;
		refs = 0;
		steps = 0;
		cyc(16);
		arst_n = 1'h1;
		for (int m = 0; m < 4; m++) begin
			eval_mode = sqw_pkg::sqw_eval_t'(m);
			use_diff = 1'($random(seed));
			ref_present = m[0];
			for (int k = 0; k < 12; k++) begin
				step_reverse = 1'($random(seed));
				ref_mark = 1'($random(seed));
				p0 = pos;
				d = step_reverse ? -1 : 1;
				nx = (idx + 4 + d) % 4;
				step_req = 1'h1;
				cyc(1);
				step_req = 1'h0;
				// Counted edges: 1x rising forward and falling in reverse, 2x first track
				if (m == 0 || m == 3)
					pos += d;
				else if (seq[idx][0] != seq[nx][0] && (m == 2 || seq[nx][0] != step_reverse))
					pos += d;
				if (pos != p0)
					steps++;
				if (nx == 2 && m[0] && ref_mark)
					refs++;
				idx = nx;
				cyc(8);
				chk({sqw_link_if_i.incr_track_second, sqw_link_if_i.incr_track_first}, seq[idx]);
				chk(position_q, pos);
				chk(phase_q, idx);
			end
			chk(ref_cnt, refs);
			chk(step_cnt, steps);
			chk(err_cnt, 0);
		end
		chk(sqw_link_if_i.fault_indication_n, 1'h1);
		malfunction = 1'h1;
		cyc(2);
		malfunction = 1'h0;
		cyc(2);
		chk(sqw_link_if_i.fault_indication_n, 1'h0);
		cyc(FC - 6);
		chk(sqw_link_if_i.fault_indication_n, 1'h0);
		chk(fault_q, 1'h1);
		cyc(10);
		chk(sqw_link_if_i.fault_indication_n, 1'h1);
		chk(fault_q, 1'h0);
		// A fault that outlasts the width, with the counter ignoring the line
		fault_present = 1'h0;
		malfunction = 1'h1;
		cyc(FC + 8);
		chk(sqw_link_if_i.fault_indication_n, 1'h0);
		chk(fault_q, 1'h0);
		malfunction = 1'h0;
		cyc(4);
		chk(sqw_link_if_i.fault_indication_n, 1'h1);
		wrap_up();
	end
endmodule
`default_nettype wire
